// ### bss_pkg.sv
// Purpose: shared constants and types for the buck startup sequencer
// Assumes: 20 MHz core clock
// Notes: reference codes are 1 mV each, rail codes 1/16 V each
package bss_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int CLK_KHZ = 20000;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int REF_MV = 500;
   localparam int RAMP_DEF_MS = 2;
   localparam int STEP_PER_MS = MS_CYC / REF_MV;
   localparam int LS_HOLD = 16;
   localparam int LS_FULL = 8;
   localparam int SLEW_PER = 8;
   localparam int SYNC_TO = 200;
   localparam int SYNC_MIN = 13;
   // ---------------------------------------------------------------
   // reset values and limits
   // ---------------------------------------------------------------
   localparam logic [10:0] FSW_DEF = 11'h25F;
   localparam logic [10:0] FSW_MIN = 11'h0FA;
   localparam logic [10:0] FSW_MAX = 11'h5DC;
   localparam logic [7:0] VIN_UV_DEF = 8'h10;
   localparam logic [6:0] DLY_DEF = 7'h00;
   localparam logic [6:0] RISE_DEF = 7'h02;
   localparam logic [7:0] PER_DEF = 8'h20;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_OPER = 8'h00;
   localparam logic [7:0] OFS_VON = 8'h04;
   localparam logic [7:0] OFS_VOFF = 8'h08;
   localparam logic [7:0] OFS_DLY = 8'h0C;
   localparam logic [7:0] OFS_RISE = 8'h10;
   localparam logic [7:0] OFS_FSW = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_VIN = 8'h1C;
   localparam int OP_ON_BIT = 0;
   localparam int OP_CTL_BIT = 1;
   // synchroniser lanes
   localparam int SY_ON = 0;
   localparam int SY_VON = 1;
   localparam int SY_VOFF = 2;
   localparam int SY_POR = 3;
   localparam int SY_CLK = 4;
   localparam int SY_PWM = 5;
   localparam int SY_OCP = 6;
   localparam int SY_OVP = 7;
   localparam int SY_W = 8;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bss_bus_t;

   typedef enum logic [2:0] {
      ST_RESET, ST_INIT, ST_IDLE, ST_DELAY, ST_RAMP, ST_ON
   } bss_st_t;

   typedef struct packed {
      bss_st_t st;
      logic [SY_W-1:0] sy0, sy1, sy2, lv;
      logic rail, analog, tracking, sync_init, clk_fault;
      logic [3:0] fidx;
      logic op_on, op_ctl;
      logic [7:0] vin_on, vin_off;
      logic [6:0] dly, rise, ms_left;
      logic [10:0] fsw;
      logic [14:0] msc;
      logic [12:0] stc;
      logic [9:0] ref_code;
      logic [7:0] pcnt, per, ext_per, ext_cnt;
      logic ext_ok;
      logic [2:0] slew;
      logic [3:0] ls_step, ls_hold;
      logic hs_seen, hs, ls, conv;
      logic [31:0] rdata;
   } bss_state_t;

   function automatic logic [10:0] bss_strap_khz(input logic [3:0] i);
      case (i)
         4'h0: return 11'h132;
         4'h1: return 11'h164;
         4'h2: return 11'h190;
         4'h3: return 11'h1BC;
         4'h4: return 11'h1F4;
         4'h5: return 11'h226;
         4'h6: return 11'h258;
         4'h7: return 11'h2C2;
         4'h8: return 11'h2EE;
         4'h9: return 11'h320;
         4'hA: return 11'h39B;
         4'hB: return 11'h3E8;
         4'hC: return 11'h443;
         4'hD: return 11'h4B0;
         4'hE: return 11'h535;
         default: return 11'h5DC;
      endcase
   endfunction
endpackage

// ### bss_sequencer.sv
// Purpose: startup, frequency and shutdown sequencing of a buck stage
// Assumes: comparators and pins are asynchronous; straps static in init
// Notes: registers are writable only in digital mode
//
// How it works
// (RULE_01) convert only with rail and turn-on ok
// (RULE_02) rail lockout 1 V, overridable by registers
// (RULE_03) input voltage code is telemetry only
// (RULE_04) low side off until first high pulse
// (RULE_05) low side eighths, 16 periods each step
// (RULE_06) ramp waits enable, rail, memory loaded
// (RULE_07) analog ramp zero to 0.5 V in 2 ms
// (RULE_08) digital start delay 0..127 ms
// (RULE_09) digital rise time 1..127 ms
// (RULE_10) host keeps soft-start slew low
// (RULE_11) overcurrent and overvoltage armed during startup
// (RULE_12) strap sampled once at init
// (RULE_13) strap picks one of sixteen frequencies
// (RULE_14) digital frequency 607 kHz, 250..1500 settable
// (RULE_15) host prefers offset frequency values
// (RULE_16) analog early clock lost means shutdown
// (RULE_17) late clock lost falls back free-running
// (RULE_18) frequency moves gradually to new target
// (RULE_19) digital free-running from internal setting
// (RULE_20) tracking chosen by low select strap
// (RULE_21) turn-on low kills both gates at once
// (RULE_22) digital host may shut down by register
// (RULE_23) floating address strap means analog mode
// (RULE_24) held in reset until supplies valid
// (RULE_25) ramp steps at fixed derived interval
// (RULE_26) comparators synchronised before use
`timescale 1ns/1ps
module bss_sequencer #(
   parameter int MS_CYCLES = bss_pkg::MS_CYC
) (
   // clock, reset, enable
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   // register port
   input wire bss_pkg::bss_bus_t bus_in,
   output logic [31:0] rd_data_out,
   // asynchronous comparators and pins
   input wire logic turn_on_in,
   input wire logic vin_above_on_in,
   input wire logic vin_above_off_in,
   input wire logic por_ok_in,
   input wire logic freq_strap_sync_in,
   input wire logic pwm_cmp_in,
   input wire logic ocp_trip_in,
   input wire logic ovp_trip_in,
   // converter results and straps
   input wire logic mem_loaded_in,
   input wire logic strap_valid_in,
   input wire logic [9:0] strap_code_in,
   input wire logic addr_float_in,
   input wire logic tracking_select_in,
   input wire logic [9:0] vin_code_in,
   // power stage
   output logic high_side_gate_out,
   output logic low_side_gate_out,
   output logic conv_en_out,
   output logic [9:0] vref_code_out,
   output logic [7:0] vin_on_code_out,
   output logic [7:0] vin_off_code_out,
   output logic [7:0] period_out,
   // status
   output logic analog_mode_out,
   output logic tracking_mode_out,
   output logic sync_fault_out
);
   import bss_pkg::*;

   bss_state_t s, n;
   logic en, tick, pend, edge_clk, shut;
   logic [10:0] fk;
   logic [7:0] free_per, tgt_per;
   logic [11:0] lsl;
   logic [12:0] intv;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      n = s;
      n.rdata = 32'h0000_0000;
      // three-stage synchronisers, second and third must agree
      n.sy0 = {ovp_trip_in, ocp_trip_in, pwm_cmp_in, freq_strap_sync_in,
               por_ok_in, vin_above_off_in, vin_above_on_in, turn_on_in}; // RULE_26
      n.sy1 = s.sy0;
      n.sy2 = s.sy1;
      n.lv = (s.sy1 & s.sy2) | (s.lv & (s.sy1 | s.sy2)); // RULE_26
      // rail lockout hysteresis from the two threshold comparators
      if (s.lv[SY_VON]) begin
         n.rail = 1'b1; // RULE_02
      end else if (!s.lv[SY_VOFF]) begin
         n.rail = 1'b0; // RULE_02
      end

      // external clock presence and period
      edge_clk = s.lv[SY_CLK] && !(s.sy1[SY_CLK] && s.sy2[SY_CLK]) ? 1'b0 :
                 (n.lv[SY_CLK] && !s.lv[SY_CLK]);
      // the count holds clocks since the last edge; a gap that ran into the
      // timeout is no period, so a single stray edge never claims a clock
      if (edge_clk) begin
         if (s.ext_cnt != 8'(SYNC_TO) && s.ext_cnt >= 8'(SYNC_MIN - 1)) begin
            n.ext_per = s.ext_cnt + 8'h01; // RULE_18
            n.ext_ok = 1'b1;
         end
         n.ext_cnt = 8'h00;
      end else if (s.ext_cnt != 8'(SYNC_TO)) begin
         n.ext_cnt = s.ext_cnt + 8'h01;
      end else begin
         n.ext_ok = 1'b0;
      end

      // free-running frequency
      if (!s.analog) begin
         fk = s.fsw; // RULE_19 RULE_14
      end else if (s.sync_init) begin
         fk = FSW_DEF;
      end else begin
         fk = bss_strap_khz(s.fidx); // RULE_13
      end
      free_per = 8'(CLK_KHZ / int'(fk));
      // a late clock lost simply drops back to free_per
      tgt_per = s.ext_ok ? s.ext_per : free_per; // RULE_17

      // switching period counter and gradual slew
      pend = (s.pcnt >= s.per - 8'h01);
      n.pcnt = pend ? 8'h00 : s.pcnt + 8'h01;
      if (pend) begin
         n.slew = s.slew + 3'h1;
         if (s.slew == 3'(SLEW_PER - 1)) begin
            if (s.per < tgt_per) begin
               n.per = s.per + 8'h01; // RULE_18
            end else if (s.per > tgt_per) begin
               n.per = s.per - 8'h01; // RULE_18
            end
         end
      end

      // early clock in analog mode is mandatory once it was there
      if (s.analog && s.sync_init && !s.ext_ok && s.st != ST_INIT &&
          s.st != ST_RESET) begin
         n.clk_fault = 1'b1; // RULE_16
      end

      en = s.lv[SY_ON] && s.rail && !s.clk_fault &&
           (s.analog || !s.op_ctl || s.op_on); // RULE_01 RULE_22
      shut = !en;
      tick = (s.msc == 15'(MS_CYCLES - 1));
      intv = s.analog ? 13'(RAMP_DEF_MS * STEP_PER_MS) :
             13'(int'(s.rise) * STEP_PER_MS); // RULE_25

      // ------------------------------------------------------------
      // sequencing
      // ------------------------------------------------------------
      case (s.st)
         ST_RESET: begin
            if (s.lv[SY_POR]) begin
               n.st = ST_INIT; // RULE_24
            end
         end
         ST_INIT: begin
            if (mem_loaded_in && strap_valid_in) begin
               n.analog = addr_float_in; // RULE_23
               n.tracking = !tracking_select_in; // RULE_20
               n.fidx = strap_code_in[9:6]; // RULE_12
               n.sync_init = s.ext_ok;
               n.st = ST_IDLE; // RULE_06
            end
         end
         ST_IDLE: begin
            n.ref_code = 10'h000;
            n.ls_step = 4'h1;
            n.ls_hold = 4'h0;
            n.hs_seen = 1'b0;
            n.msc = 15'h0000;
            n.stc = 13'h0000;
            n.ms_left = s.dly;
            if (en) begin
               n.st = (s.analog || s.dly == 7'h00) ? ST_RAMP : ST_DELAY; // RULE_06
            end
         end
         ST_DELAY: begin
            n.msc = tick ? 15'h0000 : s.msc + 15'h0001;
            if (tick) begin
               n.ms_left = s.ms_left - 7'h01; // RULE_08
               if (s.ms_left == 7'h01) begin
                  n.st = ST_RAMP;
               end
            end
         end
         ST_RAMP: begin
            if (s.tracking) begin
               n.ref_code = 10'(REF_MV);
               n.st = ST_ON;
            end else if (s.stc >= intv - 13'h0001) begin
               n.stc = 13'h0000;
               n.ref_code = s.ref_code + 10'h001; // RULE_07 RULE_09
               if (s.ref_code == 10'(REF_MV - 1)) begin
                  n.st = ST_ON;
               end
            end else begin
               n.stc = s.stc + 13'h0001;
            end
         end
         ST_ON: begin
         end
         default: n.st = ST_RESET;
      endcase
      if (s.st != ST_RESET && s.st != ST_INIT && s.st != ST_IDLE && shut) begin
         n.st = ST_IDLE; // RULE_21
      end
      if (!s.lv[SY_POR]) begin
         n.st = ST_RESET; // RULE_24
      end

      // ------------------------------------------------------------
      // gate drive
      // ------------------------------------------------------------
      n.conv = (n.st == ST_RAMP || n.st == ST_ON);
      lsl = {4'h0, s.per} * {8'h00, s.ls_step};
      n.hs = n.conv && s.lv[SY_PWM] && !s.lv[SY_OCP] && !s.lv[SY_OVP]; // RULE_11
      // an overcurrent trip parks both switches, not just the high side
      n.ls = n.conv && !s.lv[SY_PWM] && !s.lv[SY_OCP] && !s.lv[SY_OVP] && // RULE_04 RULE_11
             s.hs_seen && (s.ls_step >= 4'(LS_FULL) || s.pcnt < lsl[10:3]); // RULE_05
      if (n.hs) begin
         n.hs_seen = 1'b1;
      end
      if (pend && s.hs_seen && s.ls_step < 4'(LS_FULL)) begin
         n.ls_hold = s.ls_hold + 4'h1;
         if (s.ls_hold == 4'(LS_HOLD - 1)) begin
            n.ls_step = s.ls_step + 4'h1; // RULE_05
         end
      end

      // ------------------------------------------------------------
      // register port
      // ------------------------------------------------------------
      if (bus_in.wr && !s.analog && s.st != ST_RESET && s.st != ST_INIT) begin // RULE_23
         case (bus_in.addr)
            OFS_OPER: begin
               n.op_on = bus_in.wdata[OP_ON_BIT]; // RULE_22
               n.op_ctl = bus_in.wdata[OP_CTL_BIT];
            end
            OFS_VON: n.vin_on = bus_in.wdata[7:0]; // RULE_02
            OFS_VOFF: n.vin_off = bus_in.wdata[7:0]; // RULE_02
            OFS_DLY: n.dly = bus_in.wdata[6:0]; // RULE_08
            OFS_RISE: begin
               // zero would stall the ramp, so it reads back as 1 ms
               n.rise = (bus_in.wdata[6:0] == 7'h00) ? 7'h01 : bus_in.wdata[6:0]; // RULE_09
            end
            OFS_FSW: begin
               if (bus_in.wdata[31:11] != 21'h0 || bus_in.wdata[10:0] > FSW_MAX) begin
                  n.fsw = FSW_MAX; // RULE_14
               end else if (bus_in.wdata[10:0] < FSW_MIN) begin
                  n.fsw = FSW_MIN; // RULE_14
               end else begin
                  n.fsw = bus_in.wdata[10:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (bus_in.rd && !s.analog) begin
         case (bus_in.addr)
            OFS_OPER: n.rdata = {30'h0, s.op_ctl, s.op_on};
            OFS_VON: n.rdata = {24'h0, s.vin_on};
            OFS_VOFF: n.rdata = {24'h0, s.vin_off};
            OFS_DLY: n.rdata = {25'h0, s.dly};
            OFS_RISE: n.rdata = {25'h0, s.rise};
            OFS_FSW: n.rdata = {21'h0, s.fsw};
            OFS_STAT: n.rdata = {16'h0, s.per, 1'b0, s.st, s.ext_ok,
                                 s.clk_fault, s.tracking, s.rail};
            OFS_VIN: n.rdata = {22'h0, vin_code_in}; // RULE_03
            default: n.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s <= '0;
         s.op_on <= 1'b1;
         s.vin_on <= VIN_UV_DEF;
         s.vin_off <= VIN_UV_DEF;
         s.dly <= DLY_DEF;
         s.rise <= RISE_DEF;
         s.fsw <= FSW_DEF;
         s.per <= PER_DEF;
         s.analog <= 1'b1;
         // no edge seen yet, so the first one cannot measure a period
         s.ext_cnt <= 8'(SYNC_TO);
      end else if (clk_en_in) begin
         s <= n;
      end
   end

   assign rd_data_out = s.rdata;
   assign high_side_gate_out = s.hs;
   assign low_side_gate_out = s.ls;
   assign conv_en_out = s.conv;
   assign vref_code_out = s.ref_code;
   assign vin_on_code_out = s.vin_on;
   assign vin_off_code_out = s.vin_off;
   assign period_out = s.per;
   assign analog_mode_out = s.analog;
   assign tracking_mode_out = s.tracking;
   assign sync_fault_out = s.clk_fault;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   a_conv_needs_en: assert property (clk_en_in && !s.conv ##1 s.conv // RULE_01
      |-> $past(s.lv[SY_ON] && s.rail)) else $error("conversion without enable");
   a_ls_after_hs: assert property (s.ls |-> s.hs_seen) // RULE_04
      else $error("low side before first high pulse");
   a_ls_step_cap: assert property (s.ls_step <= 4'(LS_FULL)) // RULE_05
      else $error("low side step beyond full");
   a_ramp_after_init: assert property ($rose(s.st == ST_RAMP) // RULE_06
      |-> $past(s.st == ST_IDLE || s.st == ST_DELAY)) else $error("ramp skipped init");
   a_ref_ceiling: assert property (s.ref_code <= 10'(REF_MV)) // RULE_07
      else $error("reference past 0.5 V");
   a_delay_bound: assert property (s.st == ST_DELAY |-> s.ms_left <= s.dly) // RULE_08
      else $error("delay exceeds setting");
   a_rise_nonzero: assert property (s.rise != 7'h00) // RULE_09
      else $error("rise time zero");
   a_ocp_gate: assert property (clk_en_in && s.lv[SY_OCP] |=> !s.hs) // RULE_11
      else $error("high side on in overcurrent");
   a_strap_once: assert property (s.st inside {ST_IDLE, ST_DELAY, ST_RAMP, ST_ON} // RULE_12
      && clk_en_in |=> $stable(s.fidx)) else $error("strap resampled");
   a_fsw_range: assert property (s.fsw >= FSW_MIN && s.fsw <= FSW_MAX) // RULE_14
      else $error("frequency setting out of range");
   a_fault_off: assert property (s.clk_fault && clk_en_in |=> !s.conv) // RULE_16
      else $error("converting after clock failure");
   a_slew_step: assert property (clk_en_in |=> (s.per == $past(s.per) || // RULE_18
      s.per == $past(s.per) + 8'h01 || s.per == $past(s.per) - 8'h01))
      else $error("period jumped");
   a_shut_now: assert property (clk_en_in && s.st == ST_ON && !s.lv[SY_ON] // RULE_21
      |=> !s.hs && !s.ls && !s.conv) else $error("gates survive shutdown");
   a_analog_ro: assert property (s.analog && bus_in.wr && clk_en_in // RULE_23
      |=> $stable(s.dly) && $stable(s.fsw)) else $error("analog mode took a write");
   a_por_hold: assert property (clk_en_in && !s.lv[SY_POR] |=> s.st == ST_RESET) // RULE_24
      else $error("left reset without supplies");
   // gate, ramp and sync guards
   a_rail_gate: assert property (clk_en_in && !s.rail && s.st == ST_IDLE |=> !s.conv) // RULE_02
      else $error("converting below rail lockout");
   a_ls_ocp_off: assert property (clk_en_in && s.lv[SY_OCP] |=> !s.ls) // RULE_11
      else $error("low side on in overcurrent");
   a_ref_step: assert property (clk_en_in && s.st == ST_RAMP && !s.tracking // RULE_07
      |=> s.ref_code - $past(s.ref_code) <= 10'h001) else $error("reference jumped");
   a_sync_min: assert property (s.ext_ok |-> s.ext_per >= 8'(SYNC_MIN)) // RULE_18
      else $error("sync period below minimum");
   a_hs_needs_conv: assert property (s.hs |-> s.conv) // RULE_01
      else $error("high side without conversion");

   c_reach_on: cover property (s.st == ST_RAMP ##1 s.st == ST_ON);
   c_clk_fault: cover property ($rose(s.clk_fault));
   c_ls_full: cover property (s.ls_step == 4'(LS_FULL) && s.ls);
   c_host_off: cover property (s.op_ctl && !s.op_on && s.st == ST_IDLE);
   c_sync_lock: cover property ($rose(s.ext_ok));
endmodule

// ### bss_sync_src.sv
// Purpose: far-side model, external sync clock source on the strap pin
// Assumes: clocked by the bench clock, half period given in clocks
// Notes: pin rests low between bursts, like an idle pull-down would hold it
`timescale 1ns/1ps
module bss_sync_src (
   // clock and control
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic [7:0] half_in,
   // pin
   output logic sync_out
);
   logic [7:0] cnt;
   initial begin
      cnt = 8'h00;
      sync_out = 1'b0;
   end
   // stays applied until the bench stops it; stopping it models a lost clock
   always @(posedge clk_in) begin
      if (!run_in) begin
         cnt <= 8'h00;
         sync_out <= 1'b0;
      end else if (cnt + 8'h01 >= half_in) begin
         cnt <= 8'h00;
         sync_out <= !sync_out;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// ### tb_bss_sequencer.sv
// Purpose: self-checking bench for the startup and frequency sequencer
// Assumes: 20 MHz clock, ms counter shortened to 20 clocks
// Notes: an integer register model predicts the readback of every writable register
`timescale 1ns/1ps
module tb_bss_sequencer;
   import bss_pkg::*;
   localparam int MSC = 20;
   localparam int RAMP2 = 2 * CLK_KHZ;
   logic clk, rst, ton, von, pok, pwm, ocp, ovp, mem, afl, trk, srun, sync;
   logic hs, ls, conv, ana, tmode, sfault, amode, hs_seen;
   logic [9:0] strap, vin, vref;
   logic [7:0] von_c, voff_c, per, pp, half;
   logic [4:0] pcnt, mon;
   logic [31:0] rdd, rng;
   bss_bus_t bus;
   int num_errors, cmp_count, exp_per, t0;
   int cyc = 0;
   int mreg[int];

   bss_sequencer #(.MS_CYCLES(MSC)) DUT (
      .core_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1), .bus_in(bus), .rd_data_out(rdd),
      .turn_on_in(ton), .vin_above_on_in(von), .vin_above_off_in(von), .por_ok_in(pok),
      .freq_strap_sync_in(sync), .pwm_cmp_in(pwm), .ocp_trip_in(ocp), .ovp_trip_in(ovp),
      .mem_loaded_in(mem), .strap_valid_in(1'b1), .strap_code_in(strap),
      .addr_float_in(afl), .tracking_select_in(trk), .vin_code_in(vin),
      .high_side_gate_out(hs), .low_side_gate_out(ls), .conv_en_out(conv),
      .vref_code_out(vref), .vin_on_code_out(von_c), .vin_off_code_out(voff_c),
      .period_out(per), .analog_mode_out(ana), .tracking_mode_out(tmode),
      .sync_fault_out(sfault));
   bss_sync_src SRC (.clk_in(clk), .run_in(srun), .half_in(half), .sync_out(sync));

   assign mon = {!hs && !ls, vref == 10'h1F4, per == 8'(exp_per), sfault, conv};

   initial begin
      clk = 1'b0;
      forever #25 clk = !clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic int mfix(input logic [7:0] a, input int d);
      case (a)
         OFS_OPER: return d & 3;
         OFS_DLY: return d & 127;
         OFS_RISE: return (d & 127) == 0 ? 1 : d & 127;
         OFS_FSW: return d < 250 ? 250 : (d > 1500 ? 1500 : d);
         default: return d & 255;
      endcase
   endfunction

   function automatic logic [31:0] mexp(input logic [7:0] a);
      if (amode || !mreg.exists(int'(a))) return 32'h0;
      return mreg[int'(a)];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
      if (!amode && mreg.exists(int'(a))) mreg[int'(a)] = mfix(a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 check(rdd, e);
   endtask

   task automatic waitb(input int i, input logic v, input int lim);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (mon[i] !== v && k < lim);
   endtask

   task automatic do_reset(input logic afloat, input logic trk_hi);
      @(posedge clk);
      rst <= 1'b1;
      afl <= afloat;
      trk <= trk_hi;
      ton <= 1'b0;
      mem <= 1'b0;
      vin <= rng[9:0];
      rng = xs(rng);
      amode = afloat;
      mreg = '{8'h00: 1, 8'h04: 16, 8'h08: 16, 8'h0C: 0, 8'h10: 2, 8'h14: 607};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check({von_c, voff_c, per}, {VIN_UV_DEF, VIN_UV_DEF, PER_DEF});
      check({conv, hs, ls, vref}, 13'h0);
   endtask

   // ------------------------------------------------------------
   // stimulus and monitors on every clock
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      pcnt <= pcnt + 5'h01;
      pwm <= pcnt < 5'h0C;
      pp <= per;
      hs_seen <= conv && (hs_seen || hs);
      if (ls && !hs_seen) check(ls, 1'b0);
      if (!rst && (per > pp + 1 || pp > per + 1)) check(per, pp);
      if (cyc == 70000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rst, ton, von, pok, ocp, ovp, mem, afl, trk, srun} = 10'h200;
      {pwm, hs_seen, pcnt, pp} = '0;
      bus = '0;
      half = 8'h14;
      strap = 10'h300;
      vin = 10'h000;
      rng = 32'h25;
      num_errors = 0;
      cmp_count = 0;
      exp_per = 32;
      // analog run: strap index 12, rail lockout, full ramp
      pok = 1'b0;
      do_reset(1'b1, 1'b1);
      @(posedge clk);
      ton <= 1'b1;
      repeat (40) @(posedge clk);
      #1 check(conv, 1'b0);
      @(posedge clk);
      {pok, mem} <= 2'b11;
      repeat (60) @(posedge clk);
      #1 check({conv, ana}, 2'b01);
      wr(OFS_FSW, 32'h3E8);
      rdc(OFS_FSW, 32'h0);
      @(posedge clk);
      von <= 1'b1;
      waitb(0, 1'b1, 12);
      check(conv, 1'b1);
      t0 = cyc;
      strap <= 10'h000;
      waitb(3, 1'b1, RAMP2 + 500);
      check(cyc - t0 > RAMP2 - 100 && cyc - t0 < RAMP2 + 100, 1'b1);
      exp_per = CLK_KHZ / 1091;
      check(per, 8'(exp_per));
      for (int f = 0; f < 2; f++) begin
         @(posedge clk);
         {ocp, ovp} <= f == 0 ? 2'b10 : 2'b01;
         repeat (8) @(posedge clk);
         #1 check({hs, ls}, 2'b00);
         {ocp, ovp} <= 2'b00;
      end
      @(posedge clk);
      ton <= 1'b0;
      waitb(0, 1'b0, 8);
      check({conv, hs, ls}, 3'b000);
      // digital run: registers, delay, slope, sync, host shutdown
      do_reset(1'b0, 1'b1);
      @(posedge clk);
      mem <= 1'b1;
      repeat (12) @(posedge clk);
      #1 check(ana, 1'b0);
      for (int a = 0; a <= 20; a += 4) rdc(8'(a), mexp(8'(a)));
      wr(OFS_RISE, 32'h0);
      rdc(OFS_RISE, mexp(OFS_RISE));
      wr(OFS_FSW, 32'h64);
      rdc(OFS_FSW, mexp(OFS_FSW));
      wr(OFS_FSW, 32'h7D0);
      rdc(OFS_FSW, mexp(OFS_FSW));
      wr(OFS_VON, 32'h30);
      wr(OFS_VOFF, 32'h20);
      #1 check({von_c, voff_c}, 16'h3020);
      wr(OFS_STAT, 32'h5);
      rdc(8'h20, 32'h0);
      rdc(OFS_VIN, {22'h0, vin});
      wr(OFS_DLY, 32'h2);
      wr(OFS_RISE, 32'h2);
      wr(OFS_FSW, 32'h3D2);
      for (int a = 0; a <= 20; a += 4) rdc(8'(a), mexp(8'(a)));
      exp_per = CLK_KHZ / 978;
      @(posedge clk);
      ton <= 1'b1;
      t0 = cyc;
      waitb(0, 1'b1, 80);
      check(cyc - t0 >= 2 * MSC && cyc - t0 <= 2 * MSC + 8, 1'b1);
      repeat (4000) @(posedge clk);
      #1 check(vref == 10'h32 || vref == 10'h31, 1'b1);
      waitb(2, 1'b1, 4000);
      check(per, 8'(exp_per));
      @(posedge clk);
      srun <= 1'b1;
      exp_per = 40;
      waitb(2, 1'b1, 8000);
      check(per, 8'(exp_per));
      @(posedge clk);
      srun <= 1'b0;
      exp_per = CLK_KHZ / 978;
      waitb(2, 1'b1, 8000);
      check({per, sfault, conv}, {8'(exp_per), 2'b01});
      wr(OFS_OPER, 32'h2);
      waitb(0, 1'b0, 10);
      check(conv, 1'b0);
      // analog run with sync present at init and tracking selected
      @(posedge clk);
      srun <= 1'b1;
      do_reset(1'b1, 1'b0);
      repeat (120) @(posedge clk); // let the sync lock before init ends
      mem <= 1'b1;
      repeat (12) @(posedge clk);
      #1 check(tmode, 1'b1);
      ton <= 1'b1;
      waitb(3, 1'b1, 40);
      check(vref, 10'h1F4);
      @(posedge clk);
      srun <= 1'b0;
      waitb(1, 1'b1, 260);
      repeat (8) @(posedge clk);
      #1 check({sfault, conv}, 2'b10);
      report_and_stop();
   end
endmodule
